// file: dcrf_fifo_if.sv
// Push, pop and level signals between the top and its RAM store.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "dcrf_map.svh"
interface dcrf_fifo_if;
    import dcrf_pkg::*;
    logic                push_valid;
    logic                push_ready;
    dcrf_word_type       push_data;
    logic                pop_valid;
    logic                pop_ready;
    dcrf_word_type       pop_data;
    logic [`DCRF_PW-1:0] limit;
    logic [`DCRF_PW-1:0] wr_level;
    logic [`DCRF_PW-1:0] rd_level;
    logic                clear;
    modport feed (output push_valid, push_data, pop_ready, limit, clear,
                  input  push_ready, pop_valid, pop_data, wr_level, rd_level);
    modport store (input  push_valid, push_data, pop_ready, limit, clear,
                   output push_ready, pop_valid, pop_data, wr_level, rd_level);
endinterface
`default_nettype wire

// file: dcrf_map.svh
// Constants for the dual-clock RAM FIFO block.
// Assumes inclusion by its bare name from the package and every design file but the synchroniser.
// Summary of operation
// - A write strobe seen on an active write-clock edge stores the write word and advances the write counter.
// - The data word is N bits wide, N being one of 1, 2, 4, 9, 18 or 36.
// - While full is high a write request is dropped and neither memory nor write counter changes.
// - While empty is high a read request changes neither memory nor read pointer.
// - Almost-full is active high and its threshold is an 8-bit input from user logic.
// - Almost-empty is active high and its threshold is an 8-bit input from user logic.
// - Write clock and read clock each select rising or falling edge as active, independently.
// - An active-high clear returns pointers and flags to the empty state.
// - A static pipe select adds or removes one output register stage on read data.
// - A static depth setting fixes the word capacity and the number of RAM blocks cascaded in depth.
// - A static width setting fixes the word width and the number of RAM blocks placed side by side.
`ifndef DCRF_MAP_SVH
`define DCRF_MAP_SVH
`define DCRF_DW        36
`define DCRF_DEPTH     16
`define DCRF_PW        5
`define DCRF_THR_W     8
`define DCRF_SEL_W     3
`define DCRF_CAS_W     3
`define DCRF_NB_W      6
`define DCRF_N1        1
`define DCRF_N2        2
`define DCRF_N4        4
`define DCRF_N9        9
`define DCRF_N18       18
`define DCRF_N36       36
`define DCRF_CAP_D2    2
`define DCRF_CAP_D4    4
`define DCRF_CAP_D8    8
`define DCRF_CAP_D16   16
`define DCRF_RAM_W     9
`define DCRF_RAM_WORDS 4
`define DCRF_SYNC_W    66
`endif

// file: dcrf_pkg.sv
// Types shared by the RAM FIFO block.
// Assumes dcrf_map.svh is on the include path.
`default_nettype none
`include "dcrf_map.svh"
package dcrf_pkg;
    typedef logic [`DCRF_DW-1:0] dcrf_word_type;
    typedef enum logic [`DCRF_SEL_W-1:0] {
        dcrf_w1, dcrf_w2, dcrf_w4, dcrf_w9, dcrf_w18, dcrf_w36
    } dcrf_width_type;
    typedef enum logic [`DCRF_SEL_W-1:0] {
        dcrf_d2, dcrf_d4, dcrf_d8, dcrf_d16
    } dcrf_depth_type;
endpackage
`default_nettype wire

// file: dcrf_ram_fifo.sv
// RAM store with Gray-coded pointers crossed between write and read sides.
// Assumes push and pop requests are one-cycle pulses on clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "dcrf_map.svh"
module dcrf_ram_fifo
    import dcrf_pkg::*;
#(
    parameter int WIDTH = `DCRF_DW,
    parameter int DEPTH = `DCRF_DEPTH
) (
    // Clock and reset
    input wire logic   clk_i,
    input wire logic   rst_n_i,
    // Push and pop sides
    dcrf_fifo_if.store port
);
    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [PW-1:0]    wbin_q, wbin_d, rbin_q, rbin_d;
    logic [PW-1:0]    wgray_q, wgray_d, rgray_q, rgray_d;
    logic [PW-1:0]    wgray_rs, rgray_ws, wbin_rs, rbin_ws;
    logic [PW-1:0]    wr_level, rd_level;
    logic [2*PW-1:0]  ptr_s;
    logic             do_push, do_pop;

    // Each side sees the other pointer late, so flags err on the safe side
    dcrf_sync #(.W(2*PW)) u_ptr_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .clr_i   (port.clear),
        .async_i ({wgray_q, rgray_q}),
        .sync_o  (ptr_s)
    );
    assign {wgray_rs, rgray_ws} = ptr_s;

    for (genvar i = 0; i < PW; i++) begin : g_dec
        assign wbin_rs[i] = ^wgray_rs[PW-1:i];
        assign rbin_ws[i] = ^rgray_ws[PW-1:i];
    end

    assign wr_level        = wbin_q - rbin_ws;
    assign rd_level        = wbin_rs - rbin_q;
    assign port.push_ready = wr_level < PW'(port.limit);
    assign port.pop_valid  = rd_level != '0;
    assign do_push         = port.push_valid && port.push_ready;
    assign do_pop          = port.pop_ready && port.pop_valid;
    assign port.wr_level   = `DCRF_PW'(wr_level);
    assign port.rd_level   = `DCRF_PW'(rd_level);
    assign port.pop_data   = `DCRF_DW'(mem_q[rbin_q[AW-1:0]]);

    always_comb begin
        mem_d = mem_q;
        if (do_push) begin
            mem_d[wbin_q[AW-1:0]] = port.push_data[WIDTH-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        mem_q <= mem_d;
    end

    always_comb begin
        wbin_d = wbin_q;
        rbin_d = rbin_q;
        if (port.clear) begin
            wbin_d = '0;
            rbin_d = '0;
        end else begin
            if (do_push) begin
                wbin_d = wbin_q + PW'(1);
            end
            if (do_pop) begin
                rbin_d = rbin_q + PW'(1);
            end
        end
        wgray_d = wbin_d ^ (wbin_d >> 1);
        rgray_d = rbin_d ^ (rbin_d >> 1);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wbin_q  <= '0;
            rbin_q  <= '0;
            wgray_q <= '0;
            rgray_q <= '0;
        end else begin
            wbin_q  <= wbin_d;
            rbin_q  <= rbin_d;
            wgray_q <= wgray_d;
            rgray_q <= rgray_d;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_PUSH_ADVANCES: assert property (
        port.push_valid && port.push_ready && !port.clear |=> wbin_q == $past(wbin_q) + PW'(1))
        else $error("accepted push did not advance write pointer");
    AST_FULL_DROPS: assert property (
        port.push_valid && !port.push_ready && !port.clear |=> $stable(wbin_q))
        else $error("push while full moved write pointer");
    AST_EMPTY_IGNORES: assert property (
        port.pop_ready && !port.pop_valid && !port.clear |=> $stable(rbin_q))
        else $error("pop while empty moved read pointer");
    AST_CLEAR_EMPTIES: assert property (
        port.clear |=> wr_level == '0 && rd_level == '0 && !port.pop_valid)
        else $error("clear did not empty the store");
    AST_GRAY_STEP: assert property (
        !$past(port.clear) |-> $onehot0(wgray_q ^ $past(wgray_q)) && $onehot0(rgray_q ^ $past(rgray_q)))
        else $error("gray pointer changed more than one bit");
endmodule
`default_nettype wire

// file: dcrf_sync.sv
// Two-flop level synchroniser with a synchronous clear.
// Assumes the clear comes from logic already on clk_i.
`timescale 1ns/1ps
`default_nettype none
module dcrf_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    // Control
    input  wire logic         clr_i,
    // Levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = clr_i ? '0 : async_i;
        sync_d = clr_i ? '0 : meta_q;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule
`default_nettype wire

// file: dcrf_top.sv
// Top of the dual-clock RAM FIFO: pin sampling, edge select, flags, read path.
// Assumes write and read clocks are slow pins sampled by clk_i at 25 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "dcrf_map.svh"
module dcrf_top
    import dcrf_pkg::*;
(
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    // Write side
    input  wire logic                     write_clk_pin_i,
    input  wire logic                     write_edge_rise_i,
    input  wire logic                     fifo_write_strobe_i,
    input  wire logic [`DCRF_DW-1:0]      write_word_bus_i,
    // Read side
    input  wire logic                     read_clk_pin_i,
    input  wire logic                     read_edge_rise_i,
    input  wire logic                     fifo_read_strobe_i,
    output logic      [`DCRF_DW-1:0]      read_word_bus_o,
    // Thresholds, clear and static setup
    input  wire logic [`DCRF_THR_W-1:0]   almost_full_threshold_i,
    input  wire logic [`DCRF_THR_W-1:0]   almost_empty_threshold_i,
    input  wire logic                     pipe_sel_i,
    input  wire logic                     fifo_clear_input_i,
    input  wire logic [`DCRF_SEL_W-1:0]   depth_sel_i,
    input  wire logic [`DCRF_SEL_W-1:0]   width_sel_i,
    // Flags and setup status
    output logic                          full_o,
    output logic                          empty_o,
    output logic                          almost_full_flag_o,
    output logic                          almost_empty_flag_o,
    output logic      [`DCRF_CAS_W-1:0]   depth_cascade_o,
    output logic      [`DCRF_CAS_W-1:0]   width_cascade_o
);
    logic [`DCRF_SYNC_W-1:0] pins_raw;
    logic [`DCRF_SYNC_W-1:0] pins_s;
    logic                    wclk_s;
    logic                    rclk_s;
    logic                    wstb_s;
    logic                    rstb_s;
    logic                    clr_s;
    logic                    pipe_s;
    logic                    wpol_s;
    logic                    rpol_s;
    dcrf_word_type           wdata_s;
    logic [`DCRF_THR_W-1:0]  afv_s;
    logic [`DCRF_THR_W-1:0]  aev_s;
    logic [`DCRF_SEL_W-1:0]  wsel_s;
    logic [`DCRF_SEL_W-1:0]  dsel_s;

    // Every pin, data included, takes the same two-flop delay so that
    // strobes and data stay aligned with the sampled clock edges
    assign pins_raw = {write_clk_pin_i, read_clk_pin_i,
                       fifo_write_strobe_i, fifo_read_strobe_i,
                       fifo_clear_input_i, write_word_bus_i,
                       almost_full_threshold_i, almost_empty_threshold_i,
                       pipe_sel_i, width_sel_i, depth_sel_i,
                       write_edge_rise_i, read_edge_rise_i};

    dcrf_sync #(.W(`DCRF_SYNC_W)) u_pin_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .clr_i   (1'b0),
        .async_i (pins_raw),
        .sync_o  (pins_s)
    );

    assign {wclk_s, rclk_s, wstb_s, rstb_s, clr_s, wdata_s, afv_s, aev_s,
            pipe_s, wsel_s, dsel_s, wpol_s, rpol_s} = pins_s;

    logic wclk_last_q;
    logic wclk_last_d;
    logic rclk_last_q;
    logic rclk_last_d;
    logic wr_edge;
    logic rd_edge;

    always_comb begin
        wclk_last_d = wclk_s;
        rclk_last_d = rclk_s;
        // A change that lands on the selected level is the active edge
        wr_edge = (wclk_s != wclk_last_q) && (wclk_s == wpol_s);
        rd_edge = (rclk_s != rclk_last_q) && (rclk_s == rpol_s);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wclk_last_q <= 1'b0;
            rclk_last_q <= 1'b0;
        end else begin
            wclk_last_q <= wclk_last_d;
            rclk_last_q <= rclk_last_d;
        end
    end

    logic [`DCRF_NB_W-1:0]  nbits;
    dcrf_word_type          mask;
    logic [`DCRF_PW-1:0]    cap;
    logic [`DCRF_CAS_W-1:0] wcas;
    logic [`DCRF_CAS_W-1:0] dcas;

    always_comb begin
        unique case (dcrf_width_type'(wsel_s))
            dcrf_w1:  nbits = `DCRF_NB_W'(`DCRF_N1);
            dcrf_w2:  nbits = `DCRF_NB_W'(`DCRF_N2);
            dcrf_w4:  nbits = `DCRF_NB_W'(`DCRF_N4);
            dcrf_w9:  nbits = `DCRF_NB_W'(`DCRF_N9);
            dcrf_w18: nbits = `DCRF_NB_W'(`DCRF_N18);
            dcrf_w36: nbits = `DCRF_NB_W'(`DCRF_N36);
            // Unused codes fall back to the widest word
            default:  nbits = `DCRF_NB_W'(`DCRF_N36);
        endcase
        unique case (dcrf_depth_type'(dsel_s))
            dcrf_d2:  cap = `DCRF_PW'(`DCRF_CAP_D2);
            dcrf_d4:  cap = `DCRF_PW'(`DCRF_CAP_D4);
            dcrf_d8:  cap = `DCRF_PW'(`DCRF_CAP_D8);
            dcrf_d16: cap = `DCRF_PW'(`DCRF_CAP_D16);
            default:  cap = `DCRF_PW'(`DCRF_CAP_D16);
        endcase
        mask = ~({`DCRF_DW{1'b1}} << nbits);
        wcas = `DCRF_CAS_W'((nbits + `DCRF_RAM_W - 1) / `DCRF_RAM_W);
        dcas = `DCRF_CAS_W'((cap + `DCRF_RAM_WORDS - 1) / `DCRF_RAM_WORDS);
    end

    dcrf_fifo_if fif ();

    assign fif.push_valid = wr_edge && wstb_s;
    assign fif.push_data  = wdata_s & mask;
    assign fif.pop_ready  = rd_edge && rstb_s;
    assign fif.limit      = cap;
    assign fif.clear      = clr_s;

    dcrf_ram_fifo #(
        .WIDTH (`DCRF_DW),
        .DEPTH (`DCRF_DEPTH)
    ) u_store (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .port    (fif)
    );

    logic          pop;
    dcrf_word_type pop_word;

    assign pop      = fif.pop_ready && fif.pop_valid;
    assign pop_word = fif.pop_data & mask;

    logic                   full_q, full_d;
    logic                   empty_q, empty_d;
    logic                   af_q, af_d;
    logic                   ae_q, ae_d;
    dcrf_word_type          data_q, data_d;
    dcrf_word_type          out_q, out_d;
    logic [`DCRF_CAS_W-1:0] wcas_q, dcas_q;

    always_comb begin
        full_d  = !fif.push_ready;
        empty_d = !fif.pop_valid;
        af_d    = `DCRF_THR_W'(fif.wr_level) >= afv_s;
        ae_d    = `DCRF_THR_W'(fif.rd_level) <= aev_s;
        if (clr_s) begin
            full_d  = 1'b0;
            empty_d = 1'b1;
            af_d    = 1'b0;
            ae_d    = 1'b1;
        end
        data_d = pop ? pop_word : data_q;
        // Pipe on trades one cycle of latency for a registered RAM output
        if (pipe_s) begin
            out_d = data_q;
        end else begin
            out_d = pop ? pop_word : out_q;
        end
        // Masked every cycle, so a width change leaves no stale high bits
        out_d = out_d & mask;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            full_q  <= 1'b0;
            empty_q <= 1'b1;
            af_q    <= 1'b0;
            ae_q    <= 1'b1;
            data_q  <= '0;
            out_q   <= '0;
            wcas_q  <= '0;
            dcas_q  <= '0;
        end else begin
            full_q  <= full_d;
            empty_q <= empty_d;
            af_q    <= af_d;
            ae_q    <= ae_d;
            data_q  <= data_d;
            out_q   <= out_d;
            wcas_q  <= wcas;
            dcas_q  <= dcas;
        end
    end

    assign full_o              = full_q;
    assign empty_o             = empty_q;
    assign almost_full_flag_o  = af_q;
    assign almost_empty_flag_o = ae_q;
    assign read_word_bus_o     = out_q;
    assign width_cascade_o     = wcas_q;
    assign depth_cascade_o     = dcas_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_pipe_two;
        ##1 (data_q == $past(pop_word)) ##1 (out_q == $past(data_q));
    endsequence

    AST_PIPE_STAGE: assert property (
        pop && pipe_s && $stable(pipe_s) |-> s_pipe_two)
        else $error("pipe on did not add one read stage");

    AST_PIPE_BYPASS: assert property (
        pop && !pipe_s |=> read_word_bus_o == $past(pop_word))
        else $error("pipe off read word not on output next cycle");

    AST_WR_EDGE: assert property (
        fif.push_valid |-> $past(wclk_s) != wclk_s && wclk_s == wpol_s)
        else $error("write accepted away from the selected edge");

    AST_RD_EDGE: assert property (
        fif.pop_ready |-> $past(rclk_s) != rclk_s && rclk_s == rpol_s)
        else $error("read accepted away from the selected edge");

    AST_AF_REACH: assert property (
        !clr_s && `DCRF_THR_W'(fif.wr_level) >= afv_s |=> almost_full_flag_o)
        else $error("almost full missing at threshold");

    AST_AE_ABOVE: assert property (
        !clr_s && `DCRF_THR_W'(fif.rd_level) > aev_s |=> !almost_empty_flag_o)
        else $error("almost empty high above threshold");

    AST_FULL_AT_CAP: assert property (
        !clr_s && fif.wr_level == cap |=> full_o)
        else $error("full not raised at selected capacity");

    AST_CLEAR_FLAGS: assert property (
        clr_s |=> empty_o && !full_o && !almost_full_flag_o && almost_empty_flag_o)
        else $error("clear did not return flags to empty");

    AST_WORD_MASK: assert property (
        $stable(mask) [*3] |-> (read_word_bus_o & ~mask) == '0)
        else $error("read word has bits above selected width");

    AST_WIDTH_CAS: assert property (
        $stable(nbits) |=> width_cascade_o * `DCRF_RAM_W >= $past(nbits)
            && (width_cascade_o - 1) * `DCRF_RAM_W < $past(nbits))
        else $error("width cascade count wrong");

    AST_DEPTH_CAS: assert property (
        $stable(cap) |=> depth_cascade_o * `DCRF_RAM_WORDS >= $past(cap)
            && (depth_cascade_o - 1) * `DCRF_RAM_WORDS < $past(cap))
        else $error("depth cascade count wrong");

    // Flags are the store's view of one cycle earlier
    AST_FULL_LEVEL: assert property (
        !clr_s |=> full_o != $past(fif.push_ready))
        else $error("full flag off the store level");

    AST_EMPTY_LEVEL: assert property (
        !clr_s |=> empty_o != $past(fif.pop_valid))
        else $error("empty flag off the store level");

    AST_AF_BELOW: assert property (
        !clr_s && `DCRF_THR_W'(fif.wr_level) < afv_s |=> !almost_full_flag_o)
        else $error("almost full high below threshold");

    AST_AE_REACH: assert property (
        !clr_s && `DCRF_THR_W'(fif.rd_level) <= aev_s |=> almost_empty_flag_o)
        else $error("almost empty missing at threshold");

    AST_OUT_HOLD: assert property (
        !pop && !pipe_s && $stable(mask) |=> $stable(read_word_bus_o))
        else $error("read word moved without a read");

    AST_CLEAR_STORE: assert property (
        clr_s |=> !fif.pop_valid && fif.push_ready)
        else $error("clear left the store occupied");

    AST_WR_ONCE: assert property (
        wr_edge |=> !wr_edge)
        else $error("write edge lasted more than one cycle");

    AST_RD_ONCE: assert property (
        rd_edge |=> !rd_edge)
        else $error("read edge lasted more than one cycle");
endmodule
`default_nettype wire

// file: dcrf_top_tb_top.sv
// Self-checking bench for the dual-clock RAM FIFO top.
// Assumes the user model drives the clock, strobe and write word pins; the bench drives the edge selects.
`timescale 1ns/1ps
`default_nettype none
`include "dcrf_map.svh"
module dcrf_top_tb_top;
    import dcrf_pkg::*;
    logic                  clk_i, rst_n_i, wr_pin, wr_rise, wr_stb, rd_pin, rd_rise, rd_stb;
    logic                  pipe, clr, full, empty, af, ae;
    logic [`DCRF_DW-1:0]   wr_bus, rd_bus;
    logic [`DCRF_THR_W-1:0] af_thr, ae_thr;
    logic [`DCRF_SEL_W-1:0] dsel, wsel;
    logic [`DCRF_CAS_W-1:0] dcas, wcas;
    int                    err_total, checks_done;
    dcrf_word_type         last;
    localparam int DCAS[8] = '{1, 1, 2, 4, 4, 4, 4, 4};
    localparam int WCAS[8] = '{1, 1, 1, 1, 2, 4, 4, 4};
    localparam int NBITS[6] = '{1, 2, 4, 9, 18, 36};

    dcrf_top u_dcrf_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .write_clk_pin_i(wr_pin),
        .write_edge_rise_i(wr_rise), .fifo_write_strobe_i(wr_stb), .write_word_bus_i(wr_bus),
        .read_clk_pin_i(rd_pin), .read_edge_rise_i(rd_rise), .fifo_read_strobe_i(rd_stb),
        .read_word_bus_o(rd_bus), .almost_full_threshold_i(af_thr),
        .almost_empty_threshold_i(ae_thr), .pipe_sel_i(pipe), .fifo_clear_input_i(clr),
        .depth_sel_i(dsel), .width_sel_i(wsel), .full_o(full), .empty_o(empty),
        .almost_full_flag_o(af), .almost_empty_flag_o(ae), .depth_cascade_o(dcas),
        .width_cascade_o(wcas));
    dcrf_user_model u_dcrf_user_model (.clk_i(clk_i), .write_edge_rise_i(wr_rise),
        .read_edge_rise_i(rd_rise), .write_clk_pin_o(wr_pin), .fifo_write_strobe_o(wr_stb),
        .write_word_bus_o(wr_bus), .read_clk_pin_o(rd_pin), .fifo_read_strobe_o(rd_stb),
        .read_word_bus_i(rd_bus));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic finish_test();
        if (err_total == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: %s flag is %b", $time, what, got);
        end
    endtask
    task automatic chk_word(input dcrf_word_type got, input dcrf_word_type exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: word %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // Clear is synchronised, so it is held a few clk_i and given time to land
    task automatic do_clear();
        clr = 1'b1;
        wait_cyc(4);
        clr = 1'b0;
        wait_cyc(4);
    endtask
    task automatic pop_chk(input dcrf_word_type exp);
        dcrf_word_type s3, s4;
        u_dcrf_user_model.pop(s3, s4);
        wait_cyc(2);
        if (pipe) begin
            chk_word(s3, last);
            chk_word(s4, exp);
        end else begin
            chk_word(s3, exp);
        end
        chk_word(rd_bus, exp);
        last = exp;
    endtask
    function automatic dcrf_word_type mk(input int i);
        return 36'h5_a5a5_0000 + dcrf_word_type'(i);
    endfunction
    function automatic dcrf_word_type ones(input int n);
        return (dcrf_word_type'(1) << n) - dcrf_word_type'(1);
    endfunction

    initial begin
        repeat (100000) @(posedge clk_i);
        err_total++;
        finish_test();
    end

    initial begin
        err_total = 0;
        checks_done = 0;
        rst_n_i = 1'b0;
        wr_rise = 1'b1;
        rd_rise = 1'b1;
        af_thr = 8'h0c;
        ae_thr = 8'h03;
        pipe = 1'b0;
        clr = 1'b0;
        dsel = 3'h3;
        wsel = 3'h5;
        last = 36'h0_0000_0000;
        wait_cyc(11);
        chk_bit(full, 1'b0, "full");
        chk_bit(empty, 1'b1, "empty");
        chk_bit(af, 1'b0, "almost_full_flag");
        chk_bit(ae, 1'b1, "almost_empty_flag");
        chk_word(rd_bus, 36'h0_0000_0000);
        wait_cyc(1);
        rst_n_i = 1'b1;
        wait_cyc(6);
        for (int c = 0; c < 8; c++) begin
            dsel = c[2:0];
            wsel = c[2:0];
            wait_cyc(5);
            chk_word(dcrf_word_type'(dcas), dcrf_word_type'(DCAS[c]));
            chk_word(dcrf_word_type'(wcas), dcrf_word_type'(WCAS[c]));
        end
        dsel = 3'h3;
        wsel = 3'h5;
        do_clear();
        // Fill to capacity, then one write that must be dropped
        for (int i = 0; i < 16; i++) begin
            u_dcrf_user_model.push(mk(i));
            wait_cyc(4);
            chk_bit(af, (i + 1) >= 12, "almost_full_flag");
            chk_bit(ae, (i + 1) <= 3, "almost_empty_flag");
            chk_bit(full, i == 15, "full");
            chk_bit(empty, 1'b0, "empty");
        end
        u_dcrf_user_model.push(mk(99));
        wait_cyc(4);
        chk_bit(full, 1'b1, "full");
        for (int i = 0; i < 16; i++) begin
            pop_chk(mk(i));
            chk_bit(ae, (15 - i) <= 3, "almost_empty_flag");
        end
        wait_cyc(4);
        chk_bit(empty, 1'b1, "empty");
        pop_chk(mk(15));
        // Every width code, bits above the word width come back as zero
        for (int c = 0; c < 6; c++) begin
            wsel = c[2:0];
            do_clear();
            u_dcrf_user_model.push(36'hf_ffff_ffff);
            pop_chk(ones(NBITS[c]));
        end
        wsel = 3'h5;
        // Falling edges on both sides, with the extra output stage
        wr_rise = 1'b0;
        rd_rise = 1'b0;
        pipe = 1'b1;
        do_clear();
        u_dcrf_user_model.push(mk(7));
        u_dcrf_user_model.push(mk(8));
        pop_chk(mk(7));
        pop_chk(mk(8));
        wr_rise = 1'b1;
        rd_rise = 1'b1;
        pipe = 1'b0;
        // Four-word depth: the fifth write is dropped
        dsel = 3'h1;
        do_clear();
        for (int i = 0; i < 5; i++) begin
            u_dcrf_user_model.push(mk(20 + i));
        end
        wait_cyc(4);
        chk_bit(full, 1'b1, "full");
        for (int i = 0; i < 4; i++) begin
            pop_chk(mk(20 + i));
        end
        wait_cyc(4);
        chk_bit(empty, 1'b1, "empty");
        // Clear with data stored, then a read that must be ignored
        dsel = 3'h3;
        for (int i = 0; i < 3; i++) begin
            u_dcrf_user_model.push(mk(40 + i));
        end
        do_clear();
        chk_bit(empty, 1'b1, "empty");
        chk_bit(full, 1'b0, "full");
        chk_bit(ae, 1'b1, "almost_empty_flag");
        chk_bit(af, 1'b0, "almost_full_flag");
        pop_chk(mk(23));
        finish_test();
    end
endmodule
`default_nettype wire

// file: dcrf_user_model.sv
// User logic on the far side of the FIFO: makes write and read clock pulses.
// Assumes the caller has the FIFO out of reset and static setup settled.
`timescale 1ns/1ps
`default_nettype none
`include "dcrf_map.svh"
module dcrf_user_model
    import dcrf_pkg::*;
(
    // Clock and edge selects
    input  wire logic                clk_i,
    input  wire logic                write_edge_rise_i,
    input  wire logic                read_edge_rise_i,
    // Write side
    output logic                     write_clk_pin_o,
    output logic                     fifo_write_strobe_o,
    output logic      [`DCRF_DW-1:0] write_word_bus_o,
    // Read side
    output logic                     read_clk_pin_o,
    output logic                     fifo_read_strobe_o,
    input  wire logic [`DCRF_DW-1:0] read_word_bus_i
);
    logic wr_act;
    logic rd_act;
    initial begin
        wr_act              = 1'b0;
        rd_act              = 1'b0;
        fifo_write_strobe_o = 1'b0;
        fifo_read_strobe_o  = 1'b0;
        write_word_bus_o    = 36'h0_0000_0000;
    end
    // Idle level is the inactive one, so a pulse gives exactly one active edge
    assign write_clk_pin_o = wr_act ? write_edge_rise_i : ~write_edge_rise_i;
    assign read_clk_pin_o  = rd_act ? read_edge_rise_i : ~read_edge_rise_i;
    // Strobe falls with the inactive edge, so a wrong-edge take is seen
    task automatic push(input dcrf_word_type w);
        @(posedge clk_i);
        #1 fifo_write_strobe_o = 1'b1;
        write_word_bus_o = w;
        @(posedge clk_i);
        #1 wr_act = 1'b1;
        repeat (4) @(posedge clk_i);
        #1 wr_act = 1'b0;
        fifo_write_strobe_o = 1'b0;
        // Released bus does not keep the last word
        write_word_bus_o = ~w;
        repeat (4) @(posedge clk_i);
        #1;
    endtask
    // Samples the read word 3 and 4 clk_i edges after the active edge
    task automatic pop(output dcrf_word_type s3, output dcrf_word_type s4);
        @(posedge clk_i);
        #1 fifo_read_strobe_o = 1'b1;
        @(posedge clk_i);
        #1 rd_act = 1'b1;
        repeat (3) @(posedge clk_i);
        #1 s3 = read_word_bus_i;
        @(posedge clk_i);
        #1 s4 = read_word_bus_i;
        repeat (3) @(posedge clk_i);
        #1 rd_act = 1'b0;
        fifo_read_strobe_o = 1'b0;
        repeat (4) @(posedge clk_i);
        #1;
    endtask
endmodule
`default_nettype wire
